// ---- design/btc_pkg.sv ----
// constants for the bit-test and call execution unit
// assumes a byte-wide core bus with one access per bus cycle
package btc_pkg;
  // opcodes
  localparam logic [7:0] OP_TEST_AB = 8'h94;
  localparam logic [7:0] OP_TEST_AI = 8'h96;
  localparam logic [7:0] OP_TEST_BI = 8'h97;
  localparam logic [7:0] OP_PREFIX = 8'hCE;
  localparam logic [7:0] OP_CALL_IND = 8'hFB;
  localparam logic [7:0] OP_CALL_LONG = 8'hF2;
  localparam logic [7:0] OP_CALL_SHORT = 8'hF0;
  localparam logic [5:0] OP_CCALL_LONG_HI = 6'h3A;
  localparam logic [5:0] OP_CCALL_SHORT_HI = 6'h38;
  localparam logic [7:0] OP_TEST_BRI = 8'hDC;
  localparam logic [7:0] OP_TEST_HLI = 8'h9D;
  // condition field codes
  localparam logic [1:0] CC_CARRY = 2'h0;
  localparam logic [1:0] CC_NCARRY = 2'h1;
  localparam logic [1:0] CC_ZERO = 2'h2;
  localparam logic [1:0] CC_NZERO = 2'h3;
  // flag positions in the system condition register
  localparam int FLAG_Z = 0;
  localparam int FLAG_C = 1;
  localparam int FLAG_N = 3;
  // reset values
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] SP_RESET = 16'h0000;
  localparam logic [7:0] SC_RESET = 8'hC0;
  localparam logic [7:0] BANK_RESET = 8'h00;
  // return address offsets
  localparam logic [15:0] RET3 = 16'h0003;
  localparam logic [15:0] RET2 = 16'h0002;
  localparam logic [15:0] ONE = 16'h0001;
  // bus cycle counts
  localparam logic [3:0] CYC_CL_MIN = 4'h5;
  localparam logic [3:0] CYC_CL_MAX = 4'h6;
  localparam logic [3:0] CYC_CL_NT = 4'h3;
  localparam logic [3:0] CYC_CS_MIN = 4'h4;
  localparam logic [3:0] CYC_CS_MAX = 4'h5;
  localparam logic [3:0] CYC_CS_NT = 4'h2;
  typedef enum logic [6:0] {
    ST_FETCH = 7'h01,
    ST_OPER = 7'h02,
    ST_READ = 7'h04,
    ST_VEC = 7'h08,
    ST_PUSH = 7'h10,
    ST_DONE = 7'h20,
    ST_TRAP = 7'h40
  } btc_state_e;
endpackage

// ---- design/btc_exec.sv ----
// execution unit for bit tests and subroutine calls of an 8-bit core
// assumes a byte memory with one-cycle read data and an external accumulator/B/pointer file
// How it works
// - 94H ANDs B with A, sets only N and Z, A untouched.
// - 96H ANDs an immediate byte with A for flags only.
// - every bit test sets N from bit 7 and Z on zero result.
// - short-absolute test addresses base page high, operand byte low, read only.
// - pointer-indirect test reads byte at pointer pair, ANDs immediate, no write.
// - banked models put the data page register on data page bits.
// - indirect call reads target low then high byte from operand address.
// - three-byte calls push first address plus three.
// - banked maximum mode pushes bank, PC high, PC low; SP drops three.
// - minimum or small models push PC high and low; SP drops two.
// - taken banked call copies next bank into code bank.
// - long relative target is first address plus two plus signed 16-bit.
// - untaken banked conditional call reloads next bank from code bank.
// - condition codes: carry 00, no carry 01, zero 10, not zero 11.
// - long conditional call takes 5, 6 or 3 cycles.
// - short relative call pushes first address plus two.
// - short relative target is first address plus one plus signed 8-bit.
// - small models have no bank registers; code address is logical PC.
// - small models read indirect call pointer from 16-bit address alone.
// - short conditional call takes 4, 5 or 2 cycles.
module btc_exec
  import btc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic bankedModel,
  input wire logic maxMode,
  input wire logic [7:0] accA,
  input wire logic [7:0] regB,
  input wire logic [15:0] pointerPairReg,
  input wire logic [7:0] basePageReg,
  input wire logic [7:0] dataPageReg,
  input wire logic nextBankWe,
  input wire logic [7:0] nextBankWdata,
  input wire logic [7:0] memRdata,
  output logic [23:0] memAddr,
  output logic memRd,
  output logic memWr,
  output logic [7:0] memWdata,
  output logic [15:0] pc,
  output logic [15:0] sp,
  output logic [7:0] sysCond,
  output logic [7:0] codeBankReg,
  output logic [7:0] nextBankReg,
  output logic instrDone,
  output logic badOpcode
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  btc_state_e state_q, state_d;
  logic [15:0] pc_q, pc_d, sp_q, sp_d, start_q, start_d, opnd_q, opnd_d, tgt_q, tgt_d;
  logic [7:0] sc_q, sc_d, cb_q, cb_d, nb_q, nb_d, op_q, op_d, op2_q, op2_d;
  logic [1:0] idx_q, idx_d;
  logic [3:0] cyc_q, cyc_d;
  logic prefix_q, prefix_d;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire isTestAB = (op_q == OP_TEST_AB) && !prefix_q;
  wire isTestAI = (op_q == OP_TEST_AI) && !prefix_q;
  wire isTestBI = (op_q == OP_TEST_BI) && !prefix_q;
  wire isTestBR = (op_q == OP_TEST_BRI) && !prefix_q;
  wire isTestHL = (op_q == OP_TEST_HLI) && !prefix_q;
  wire isCallInd = (op_q == OP_CALL_IND) && !prefix_q;
  wire isCallLong = (op_q == OP_CALL_LONG) && !prefix_q;
  wire isCallShort = (op_q == OP_CALL_SHORT) && !prefix_q;
  wire isCcLong = (op_q[7:2] == OP_CCALL_LONG_HI) && !prefix_q;
  wire isCcShort = (op_q[7:2] == OP_CCALL_SHORT_HI) && !prefix_q;
  wire isLong = isCallLong || isCcLong;
  wire isShortCall = isCallShort || isCcShort;
  wire isCall = isLong || isShortCall || isCallInd;
  wire isTest = isTestAB || isTestAI || isTestBI || isTestBR || isTestHL;
  // condition field evaluation
  wire [1:0] ccField = op_q[1:0];
  wire condTrue = (ccField == CC_CARRY) ? sc_q[FLAG_C] :
                  (ccField == CC_NCARRY) ? !sc_q[FLAG_C] :
                  (ccField == CC_ZERO) ? sc_q[FLAG_Z] : !sc_q[FLAG_Z];
  wire isCond = isCcLong || isCcShort;
  wire taken = !isCond || condTrue;
  // bank registers only exist in the banked models
  wire useBank = bankedModel;
  wire pushThree = useBank && maxMode;
  // operand byte counts: immediates and displacements
  wire [1:0] nOper = isTestAB ? 2'd0 : (isLong || isCallInd || isTestBR) ? 2'd2
                   : 2'd1;
  // data page only applies in banked models; small models use the logical address alone
  wire [7:0] dPage = useBank ? dataPageReg : 8'h00;
  wire [7:0] cPage = useBank ? cb_q : 8'h00;
  // test operand addresses
  wire [15:0] testAddr = isTestBR ? {basePageReg, opnd_q[7:0]}
                                  : pointerPairReg;
  wire [7:0] testImm = isTestBR ? opnd_q[15:8] : opnd_q[7:0];
  wire [7:0] retLen = isShortCall ? RET2[7:0] : RET3[7:0];
  wire [15:0] retAddr = start_q + {8'h00, retLen};
  wire [15:0] shortTgt = start_q + ONE + {{8{opnd_q[7]}}, opnd_q[7:0]};
  wire [15:0] longTgt = start_q + RET2 + opnd_q;
  wire [15:0] skipPc = start_q + (isShortCall ? RET2 : RET3);
  wire [7:0] pushByte = (pushThree && idx_q == 2'd0) ? cb_q :
                        (idx_q == (pushThree ? 2'd1 : 2'd0)) ? retAddr[15:8]
                        : retAddr[7:0];
  wire [15:0] pushAddr = sp_q - {14'h0, idx_q} - ONE;
  wire [1:0] nPush = pushThree ? 2'd3 : 2'd2;
  wire [3:0] cycTaken = isLong ? (pushThree ? CYC_CL_MAX : CYC_CL_MIN)
                               : (pushThree ? CYC_CS_MAX : CYC_CS_MIN);
  wire [3:0] cycNot = isLong ? CYC_CL_NT : CYC_CS_NT;
  // memory tests use the byte latched in the read cycle
  wire [7:0] testSrc = (isTestBR || isTestHL) ? op2_q : accA;
  wire [7:0] testMask = isTestAB ? regB : isTestBI ? testImm : testImm;
  wire [7:0] testLeft = isTestBI ? regB : testSrc;
  wire [7:0] product = testLeft & testMask;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    pc_d = pc_q;
    sp_d = sp_q;
    sc_d = sc_q;
    cb_d = cb_q;
    nb_d = nextBankWe ? nextBankWdata : nb_q;
    op_d = op_q;
    op2_d = op2_q;
    start_d = start_q;
    opnd_d = opnd_q;
    tgt_d = tgt_q;
    idx_d = idx_q;
    cyc_d = cyc_q + 4'h1;
    prefix_d = prefix_q;
    memAddr = {cPage, pc_q};
    memRd = 1'b0;
    memWr = 1'b0;
    memWdata = 8'h00;
    case (state_q)
      ST_FETCH: begin
        memRd = 1'b1;
        pc_d = pc_q + ONE;
        idx_d = 2'd0;
        if (!prefix_q) begin
          start_d = pc_q;
          cyc_d = 4'h1;
        end
        if (memRdata == OP_PREFIX && !prefix_q) begin
          prefix_d = 1'b1;
        end else begin
          op_d = memRdata;
          state_d = ST_OPER;
        end
      end
      ST_OPER: begin
        // ops with no operand fall straight through
        if (!(isTest || isCall)) begin
          state_d = ST_TRAP;
        end else if (nOper == 2'd0) begin
          state_d = ST_DONE;
        end else begin
          memRd = 1'b1;
          pc_d = pc_q + ONE;
          idx_d = idx_q + 2'd1;
          if (idx_q == 2'd0) begin
            opnd_d[7:0] = memRdata;
          end else begin
            opnd_d[15:8] = memRdata;
          end
          // decide on the last operand byte so call timing equals its bus accesses
          if (idx_q + 2'd1 == nOper) begin
            idx_d = 2'd0;
            if (isTest) begin
              state_d = (isTestBR || isTestHL) ? ST_READ : ST_DONE;
            end else if (!taken) begin
              state_d = ST_FETCH;
              prefix_d = 1'b0;
              pc_d = skipPc;
              if (useBank) begin
                nb_d = cb_q;
              end
            end else begin
              state_d = isCallInd ? ST_VEC : ST_PUSH;
            end
          end
        end
      end
      ST_READ: begin
        // bit test reads memory and never writes it back
        memRd = 1'b1;
        memAddr = {dPage, testAddr};
        op2_d = memRdata;
        state_d = ST_DONE;
      end
      ST_VEC: begin
        memRd = 1'b1;
        memAddr = {dPage, opnd_q + {15'h0, idx_q[0]}};
        idx_d = idx_q + 2'd1;
        if (idx_q == 2'd0) begin
          tgt_d[7:0] = memRdata;
        end else begin
          tgt_d[15:8] = memRdata;
          idx_d = 2'd0;
          state_d = ST_PUSH;
        end
      end
      ST_PUSH: begin
        // stack writes keep page zero
        // a frozen cycle must not repeat the write
        memWr = clkEn;
        memAddr = {8'h00, pushAddr};
        memWdata = pushByte;
        idx_d = idx_q + 2'd1;
        // the last push also commits, so no idle cycle follows
        if (idx_q + 2'd1 == nPush) begin
          state_d = ST_FETCH;
          prefix_d = 1'b0;
          idx_d = 2'd0;
          sp_d = sp_q - {14'h0, nPush};
          pc_d = isCallInd ? tgt_q : isLong ? longTgt : shortTgt;
          if (useBank) begin
            cb_d = nb_q;
          end
        end
      end
      ST_DONE: begin
        // only bit tests pass through here, to settle the flags
        state_d = ST_FETCH;
        prefix_d = 1'b0;
        if (isTest) begin
          sc_d[FLAG_N] = product[7];
          sc_d[FLAG_Z] = (product == 8'h00);
        end
      end
      ST_TRAP: begin
        state_d = ST_FETCH;
        prefix_d = 1'b0;
      end
      default: state_d = ST_FETCH;
    endcase
  end

  // ----------------------------------------
  // registers, frozen while clkEn is low
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_FETCH;
      pc_q <= PC_RESET;
      sp_q <= SP_RESET;
      sc_q <= SC_RESET;
      cb_q <= BANK_RESET;
      nb_q <= BANK_RESET;
      op_q <= 8'h00;
      op2_q <= 8'h00;
      start_q <= PC_RESET;
      opnd_q <= 16'h0000;
      tgt_q <= 16'h0000;
      idx_q <= 2'd0;
      cyc_q <= 4'h0;
      prefix_q <= 1'b0;
    end else if (clkEn) begin
      state_q <= state_d;
      pc_q <= pc_d;
      sp_q <= sp_d;
      sc_q <= sc_d;
      cb_q <= cb_d;
      nb_q <= nb_d;
      op_q <= op_d;
      op2_q <= op2_d;
      start_q <= start_d;
      opnd_q <= opnd_d;
      tgt_q <= tgt_d;
      idx_q <= idx_d;
      cyc_q <= cyc_d;
      prefix_q <= prefix_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign pc = pc_q;
  assign sp = sp_q;
  assign sysCond = sc_q;
  assign codeBankReg = cb_q;
  assign nextBankReg = nb_q;
  assign instrDone = clkEn && (state_q == ST_FETCH) && !prefix_q;
  assign badOpcode = (state_q == ST_TRAP);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  wire doneNow = clkEn && state_d == ST_FETCH
    && (state_q == ST_OPER || state_q == ST_PUSH || state_q == ST_DONE);
  property p_test_flags;
    @(posedge clk) disable iff (!reset_n)
    doneNow && isTest |=> sysCond[FLAG_N] == $past(product[7])
      && sysCond[FLAG_Z] == ($past(product) == 8'h00);
  endproperty
  a_test_flags: assert property (p_test_flags) else $error("bit test flags wrong");
  property p_test_nowrite;
    @(posedge clk) disable iff (!reset_n)
    isTest && state_q != ST_FETCH |-> !memWr;
  endproperty
  a_test_nowrite: assert property (p_test_nowrite) else $error("bit test wrote memory");
  property p_test_other_flags;
    @(posedge clk) disable iff (!reset_n)
    doneNow && isTest |=> sysCond[FLAG_C] == $past(sc_q[FLAG_C]);
  endproperty
  a_test_other_flags: assert property (p_test_other_flags) else $error("carry touched");
  property p_call_flags;
    @(posedge clk) disable iff (!reset_n)
    doneNow && isCall |=> $stable(sysCond);
  endproperty
  a_call_flags: assert property (p_call_flags) else $error("call changed flags");
  property p_sp_drop;
    @(posedge clk) disable iff (!reset_n)
    doneNow && isCall && taken |=> sp == $past(sp_q) - (pushThree ? 16'd3 : 16'd2);
  endproperty
  a_sp_drop: assert property (p_sp_drop) else $error("stack drop wrong");
  property p_bank_copy;
    @(posedge clk) disable iff (!reset_n)
    doneNow && isCall && taken && useBank |=> codeBankReg == $past(nb_q);
  endproperty
  a_bank_copy: assert property (p_bank_copy) else $error("bank not switched");
  property p_nb_restore;
    @(posedge clk) disable iff (!reset_n)
    doneNow && isCond && !condTrue && useBank |=> nextBankReg == $past(cb_q);
  endproperty
  a_nb_restore: assert property (p_nb_restore) else $error("next bank kept");
  property p_skip_pc;
    @(posedge clk) disable iff (!reset_n)
    doneNow && isCond && !condTrue |=> pc == $past(skipPc) && $stable(sp);
  endproperty
  a_skip_pc: assert property (p_skip_pc) else $error("skip pc wrong");
  property p_cycles;
    @(posedge clk) disable iff (!reset_n)
    doneNow && (isLong || isShortCall) |-> cyc_q + 4'h1 == (taken ? cycTaken : cycNot);
  endproperty
  a_cycles: assert property (p_cycles) else $error("cycle count wrong");
  c_call_long: cover property (@(posedge clk) doneNow && isLong && taken);
  c_call_skip: cover property (@(posedge clk) doneNow && isCond && !condTrue);
  c_test_mem: cover property (@(posedge clk) doneNow && isTestHL);
  c_call_ind: cover property (@(posedge clk) doneNow && isCallInd && pushThree);
endmodule

// ---- bench/btc_mem_model.sv ----
// byte-wide program and data memory on the core bus
// assumes read data is expected in the same cycle as the read strobe
module btc_mem_model (
  input wire logic clk,
  input wire logic [23:0] memAddr,
  input wire logic memRd,
  input wire logic memWr,
  input wire logic [7:0] memWdata,
  output logic [7:0] memRdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // storage and write counting
  // ----------------------------------------
  logic [7:0] store [logic [23:0]];
  int wrCount = 0;
  logic [7:0] junk = 8'hA5;

  // writes land on the rising edge; the count lets the bench spot stray writes
  always @(posedge clk) begin
    junk <= ~junk;
    if (memWr === 1'b1) begin
      store[memAddr] = memWdata;
      wrCount++;
    end
  end

  // undriven data lines toggle so a stale byte never passes for an answer
  always_comb begin
    if (memRd !== 1'b1) begin
      memRdata = junk;
    end else if (store.exists(memAddr)) begin
      memRdata = store[memAddr];
    end else begin
      memRdata = ~memAddr[7:0]; // empty cells read as a pattern of the address
    end
  end
endmodule

// ---- bench/bit_test_and_call_exec_bench.sv ----
// self-checking bench for the bit-test and call execution unit
// assumes btc_pkg and the byte memory model; random stimulus from a fixed seed
module bit_test_and_call_exec_bench import btc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  logic clk, reset_n, clkEn, bankedModel, maxMode, nextBankWe, stall, seenBad;
  logic [7:0] accA, regB, basePageReg, dataPageReg, nextBankWdata, memRdata, memWdata;
  logic [7:0] sysCond, codeBankReg, nextBankReg;
  logic [15:0] pointerPairReg, pc, sp;
  logic [23:0] memAddr;
  logic memRd, memWr, instrDone, badOpcode;
  int errors, n_tests, m, i;

  btc_exec DUT (.clk, .reset_n, .clkEn, .bankedModel, .maxMode, .accA, .regB,
    .pointerPairReg, .basePageReg, .dataPageReg, .nextBankWe, .nextBankWdata,
    .memRdata, .memAddr, .memRd, .memWr, .memWdata, .pc, .sp, .sysCond,
    .codeBankReg, .nextBankReg, .instrDone, .badOpcode);

  btc_mem_model memModel (.clk, .memAddr, .memRd, .memWr, .memWdata, .memRdata);

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------
  // compare and closing tasks
  // ----------------------------------------
  task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    chk16(nm, {8'h00, e}, {8'h00, g});
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // run until the next fetch, counting only enabled cycles; bounded wait
  task automatic step(output int ncyc);
    int k;
    ncyc = 0;
    seenBad = 1'b0;
    for (k = 0; k < 60; k++) begin
      clkEn = (k == 0 || !stall) ? 1'b1 : 1'($urandom % 4 != 0);
      @(posedge clk);
      if (clkEn) ncyc++;
      @(negedge clk);
      nextBankWe = 1'b0;
      if (badOpcode === 1'b1) seenBad = 1'b1;
      if (clkEn && instrDone === 1'b1) return;
    end
    errors++;
    complete_run();
  endtask

  // ----------------------------------------
  // one instruction: place it, run it, check it
  // ----------------------------------------
  task automatic run_one(input int kind, input logic [7:0] i8);
    logic [15:0] pc0, sp0, d16, va, tgt, ret;
    logic [7:0] b [4];
    logic [7:0] sc0, cb0, nb0, imm, dat, res, cp, dp;
    logic big, take;
    int len, wr0, ncyc, k;
    pc0 = pc;
    sp0 = sp;
    sc0 = sysCond;
    cb0 = codeBankReg;
    accA = 8'($urandom);
    regB = 8'($urandom);
    dataPageReg = 8'($urandom);
    // data and vector kept off the code bytes so they cannot clobber them
    basePageReg = pc0[15:8] ^ 8'h80;
    pointerPairReg = {pc0[15:8] ^ 8'h40, 8'($urandom)};
    nextBankWe = bankedModel;
    nextBankWdata = 8'($urandom);
    nb0 = nextBankWdata;
    cp = bankedModel ? cb0 : 8'h00;
    dp = bankedModel ? dataPageReg : 8'h00;
    imm = 8'($urandom);
    dat = 8'($urandom);
    d16 = (i8 < 18) ? (i8[0] ? 16'h7FFF : 16'h8000) : 16'($urandom);
    va = pc0 ^ 16'h8000;
    big = bankedModel & maxMode;
    take = (kind != 7 && kind != 9) || ((i8[1] ? sc0[FLAG_Z] : sc0[FLAG_C]) ^ i8[0]);
    case (kind)
      0: b = '{OP_TEST_AB, 8'h00, 8'h00, 8'h00};
      1: b = '{OP_TEST_AI, imm, 8'h00, 8'h00};
      2: b = '{OP_TEST_BRI, d16[7:0], imm, 8'h00};
      3: b = '{OP_TEST_HLI, imm, 8'h00, 8'h00};
      4: b = '{OP_CALL_IND, va[7:0], va[15:8], 8'h00};
      5: b = '{OP_CALL_LONG, d16[7:0], d16[15:8], 8'h00};
      6: b = '{OP_CALL_SHORT, d16[15:8], 8'h00, 8'h00};
      7: b = '{{OP_CCALL_LONG_HI, i8[1:0]}, d16[7:0], d16[15:8], 8'h00};
      8: b = '{OP_TEST_BI, imm, 8'h00, 8'h00};
      9: b = '{{OP_CCALL_SHORT_HI, i8[1:0]}, d16[15:8], 8'h00, 8'h00};
      default: b = '{8'h00, 8'h00, 8'h00, 8'h00};
    endcase
    for (k = 0; k < 4; k++) memModel.store[{cp, pc0 + 16'(k)}] = b[k];
    if (kind == 2) memModel.store[{dp, basePageReg, d16[7:0]}] = dat;
    if (kind == 3) memModel.store[{dp, pointerPairReg}] = dat;
    if (kind == 4) begin
      memModel.store[{dp, va}] = d16[7:0];
      memModel.store[{dp, va + 16'h0001}] = d16[15:8];
    end
    res = (kind == 0) ? accA & regB : ((kind == 1) ? accA & imm
        : ((kind == 8) ? regB & imm : dat & imm));
    tgt = (kind == 4) ? d16 : ((kind == 6 || kind == 9)
        ? pc0 + ONE + {{8{d16[15]}}, d16[15:8]} : pc0 + RET2 + d16);
    ret = pc0 + ((kind == 6 || kind == 9) ? RET2 : RET3);
    len = (kind == 0) ? 1 : ((kind == 1 || kind == 3 || kind == 8) ? 2 : 3);
    wr0 = memModel.wrCount;
    step(ncyc);
    if (kind < 4 || kind == 8) begin
      sc0[FLAG_N] = res[7];
      sc0[FLAG_Z] = (res == 8'h00);
      chk8("flags", sc0, sysCond);
      chk16("writes", 16'h0000, 16'(memModel.wrCount - wr0));
      chk16("pc", pc0 + 16'(len), pc);
      return;
    end
    chk8("flags", sc0, sysCond);
    if (kind == 10) begin
      chk8("trap", 8'h01, {7'h00, seenBad});
      chk16("sp", sp0, sp);
    end else if (take) begin
      chk16("pc", tgt, pc);
      chk16("sp", sp0 - (big ? 16'h0003 : 16'h0002), sp);
      chk8("push1", big ? cb0 : ret[15:8], memModel.store[{8'h00, sp0 - 16'h0001}]);
      chk8("push2", big ? ret[15:8] : ret[7:0], memModel.store[{8'h00, sp0 - 16'h0002}]);
      if (big) chk8("push3", ret[7:0], memModel.store[{8'h00, sp0 - 16'h0003}]);
      if (bankedModel) chk8("bank", nb0, codeBankReg);
      if (kind == 5 || kind == 7) chk16("cycles", big ? 16'h0006 : 16'h0005, 16'(ncyc));
      if (kind == 9) chk16("cycles", big ? 16'h0005 : 16'h0004, 16'(ncyc));
    end else begin
      chk16("pc", pc0 + ((kind == 9) ? RET2 : RET3), pc);
      chk16("sp", sp0, sp);
      if (bankedModel) chk8("next bank", cb0, nextBankReg);
      chk16("cycles", (kind == 9) ? 16'h0002 : 16'h0003, 16'(ncyc));
    end
  endtask

  // ----------------------------------------
  // main sequence: reset, then small (maximum pin set), banked minimum, banked maximum
  // ----------------------------------------
  initial begin
    errors = 0;
    n_tests = 0;
    reset_n = 1'b0;
    clkEn = 1'b1;
    stall = 1'b0;
    bankedModel = 1'b0;
    maxMode = 1'b0;
    accA = 8'h00;
    regB = 8'h00;
    pointerPairReg = 16'h0000;
    basePageReg = 8'h00;
    dataPageReg = 8'h00;
    nextBankWe = 1'b0;
    nextBankWdata = 8'h00;
    void'($urandom(32'hF333363C));
    repeat (10) @(negedge clk);
    chk16("pc", PC_RESET, pc);
    chk16("sp", SP_RESET, sp);
    chk8("flags", SC_RESET, sysCond);
    chk8("bank", BANK_RESET, codeBankReg);
    reset_n = 1'b1;
    // first eleven of each mode cover every kind; stalls only in banked minimum
    for (m = 0; m < 3; m++) begin
      bankedModel = (m > 0);
      maxMode = (m != 1);
      stall = (m == 1);
      for (i = 0; i < 40; i++) run_one((i < 11) ? i : int'($urandom % 11), 8'(i));
    end
    complete_run();
  end
endmodule
